/* dv/psbc_link_model.sv */
// Purpose: Link side and board clock model.
// Assumes: Frame interval scaled to 8 cycles.
// Notes: Reference clock stays low while stopped.
`timescale 1ns/1ps
`default_nettype none
module psbc_link_model (
    input wire logic core_clk,
    input wire logic sofRun,
    input wire logic refRun,
    output logic hsSofSeen,
    output logic ref_clock_in
);
    logic [2:0] cnt = 3'h0;
    initial hsSofSeen = 1'h0;
    initial ref_clock_in = 1'h0;
    always #19.231 ref_clock_in = refRun & !ref_clock_in;
    always @(posedge core_clk)
    begin
        cnt <= cnt + 3'h1;
        hsSofSeen <= sofRun && cnt == 3'h7;
    end
endmodule
`default_nettype wire

/* dv/psbc_props.sv */
// Purpose: Checker for the sideband pin control block.
// Assumes: Straps static after reset.
// Notes: Checks other than chk_clk_sticky start three edges after reset release.
`timescale 1ns/1ps
`default_nettype none
module psbc_props (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic chipSelectN,
    input wire logic chipSelect,
    input wire logic frameEnable,
    input wire logic hsSofSeen,
    input wire logic faultIn,
    input wire logic use_ext_power_indicator,
    input wire logic indicator_invert,
    input wire logic indicator_qualify_bypass,
    input wire logic busValidCmp,
    input wire logic driveBusPower,
    input wire logic switch_drive_mode,
    input wire logic refIs26M,
    input wire logic frameOut,
    input wire logic powerDown,
    input wire logic ulpiOe,
    input wire logic deadBatDetectRun,
    input wire logic extIndicator,
    input wire logic bus_power_switch_ctrl,
    input wire logic bus_power_switch_ctrl_oe,
    input wire logic ulpiClkOe,
    input wire psbc_pkg::psbc_mode_t mode
);
    import psbc_pkg::*;
    logic [2:0] up;
    wire rdy = up[2];
    wire sel = !chipSelectN && chipSelect;
    wire ind = use_ext_power_indicator & (indicator_qualify_bypass | busValidCmp) & (faultIn ^ indicator_invert);
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            up <= 3'h0;
        else
            up <= {up[1:0], 1'h1};
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    property p_switch;
        rdy |=> bus_power_switch_ctrl == ($past(driveBusPower) ^ $past(switch_drive_mode))
            && bus_power_switch_ctrl_oe == $past(driveBusPower);
    endproperty
    chk_active_mode: assert property (rdy && sel |=> mode == PSBC_ACTIVE && ulpiOe && !powerDown)
        else $error("no active");
    chk_power_down: assert property (rdy && chipSelectN |=> powerDown && !ulpiOe)
        else $error("no power down");
    chk_deadbat_ignored: assert property (rdy && sel |=> !deadBatDetectRun)
        else $error("dead battery run");
    chk_frame_off: assert property (rdy && !frameEnable |=> !frameOut)
        else $error("frame on");
    chk_frame_toggle: assert property (rdy && sel && frameEnable && hsSofSeen |=> frameOut != $past(frameOut))
        else $error("no toggle");
    chk_ind_value: assert property (rdy |=> extIndicator == $past(ind))
        else $error("indicator");
    chk_switch_drive: assert property (p_switch)
        else $error("switch");
    chk_strap_hold: assert property (rdy |=> $stable(refIs26M))
        else $error("strap moved");
    // The clock output is gated by active mode, so it only has to hold while still selected.
    chk_clk_sticky: assert property (ulpiClkOe && sel |=> ulpiClkOe)
        else $error("clock oe fell");
    cover property (rdy && sel && frameEnable && hsSofSeen);
    cover property ($rose(ulpiClkOe));
    cover property (rdy && deadBatDetectRun);
endmodule
bind psbc_top psbc_props u_props (.*);
`default_nettype wire

/* dv/tb.sv */
// Purpose: Self-checking bench for the sideband pin control block.
// Assumes: One frame every 8 cycles.
// Notes: Each scenario task (t_straps to t_clk) drives and judges one scenario.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import psbc_pkg::*;
    logic core_clk = 1'h0, nrst = 1'h0, freqSelStrap = 1'h1, chipSelectN = 1'h1, sofRun = 1'h0, refRun = 1'h0;
    logic charge_detect_polarity_strap = 1'h0, chipSelect = 1'h0, dead_battery_detect_enable_n = 1'h1;
    logic frameEnable = 1'h0, faultIn = 1'h0, use_ext_power_indicator = 1'h0, indicator_invert = 1'h0;
    logic indicator_qualify_bypass = 1'h0, busValidCmp = 1'h0, chargerDetected = 1'h0, driveBusPower = 1'h0;
    logic switch_drive_mode = 1'h0, hsSofSeen, ref_clock_in, refIs26M, frameOut, powerDown, ulpiOe, ulpiClkOe;
    logic deadBatDetectRun, extIndicator, charge_detect_out, charge_detect_out_oe, bus_power_switch_ctrl;
    logic bus_power_switch_ctrl_oe, last;
    psbc_mode_t mode;
    int n_errors = 0, checks = 0, n;
    psbc_top u_dut (.*);
    psbc_link_model u_link (.*);
    always #10 core_clk = !core_clk;
    task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic t_straps;
        @(posedge core_clk);
        chargerDetected <= 1'h1;
        freqSelStrap <= 1'h0;
        settle(2);
        chk("refIs26M", 3'h1, refIs26M);
        chk("chgLow", 3'h2, {1'h0, charge_detect_out_oe, charge_detect_out});
        @(posedge core_clk);
        nrst <= 1'h0;
        charge_detect_polarity_strap <= 1'h1;
        settle(4);
        chk("modeRst", PSBC_OFF, mode);
        @(posedge core_clk);
        nrst <= 1'h1;
        settle(4);
        chk("refIs19M", 3'h0, refIs26M);
        chk("chgHigh", 3'h3, {1'h0, charge_detect_out_oe, charge_detect_out});
    endtask
    task automatic t_select;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge core_clk);
            {chipSelectN, chipSelect} <= i[1:0] ^ 2'h1;
            dead_battery_detect_enable_n <= i[2];
            settle(4);
            chk("ulpiOe", {1'h0, i % 4 != 0, i % 4 == 0}, {1'h0, powerDown, ulpiOe});
            chk("deadBat", {2'h0, i != 0 && i != 4}, deadBatDetectRun);
        end
    endtask
    task automatic t_frame;
        @(posedge core_clk);
        sofRun <= 1'h1;
        settle(20);
        chk("frameOff", 3'h0, frameOut);
        @(posedge core_clk);
        frameEnable <= 1'h1;
        @(negedge core_clk);
        last = frameOut;
        n = 0;
        repeat (80)
        begin
            @(negedge core_clk);
            n += int'(frameOut !== last);
            last = frameOut;
        end
        chk("toggles", 3'h1, {2'h0, n == 10});
    endtask
    task automatic t_bits;
        for (int i = 0; i < 128; i++)
        begin
            @(posedge core_clk);
            {switch_drive_mode, driveBusPower, use_ext_power_indicator} <= i[6:4];
            {indicator_invert, indicator_qualify_bypass, busValidCmp, faultIn} <= i[3:0];
            settle(1);
            chk("extInd", {2'h0, i[4] & (i[2] | i[1]) & (i[0] ^ i[3])}, extIndicator);
            chk("sw", {1'h0, i[5], ^i[6:5]}, {1'h0, bus_power_switch_ctrl_oe, bus_power_switch_ctrl});
        end
    endtask
    task automatic t_clk;
        chk("clkOeIdle", 3'h0, ulpiClkOe);
        @(posedge core_clk);
        refRun <= 1'h1;
        settle(20);
        chk("clkOeOn", 3'h1, ulpiClkOe);
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge core_clk);
        nrst <= 1'h1;
        settle(4);
        t_straps;
        t_select;
        t_frame;
        t_bits;
        t_clk;
        tally_and_finish;
    end
    initial
    begin
        repeat (3000) @(posedge core_clk);
        n_errors++;
        tally_and_finish;
    end
endmodule
`default_nettype wire

/* src/psbc_pkg.sv */
// Purpose: Shared constants for the transceiver sideband pin control block.
// Assumes: One 50 MHz core clock.
// Notes: Timing figures are kept in their own units with derived cycle counts.
package psbc_pkg;
    localparam int CLK_PERIOD_PS = 20000;
    localparam int RESET_MIN_US = 100;
    localparam int RESET_MIN_CYCLES = (RESET_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic FREQ_SEL_19M2 = 1'h0;
    localparam logic FREQ_SEL_26M = 1'h1;
    localparam logic DRIVE_ACTIVE_HIGH = 1'h0;
    localparam logic DRIVE_ACTIVE_LOW = 1'h1;
    localparam logic POL_ACTIVE_LOW = 1'h0;
    localparam int REF_DETECT_EDGES = 4;
    localparam int REF_CNT_W = 3;
    typedef enum logic [2:0] {
        PSBC_OFF = 3'h1,
        PSBC_ACTIVE = 3'h2,
        PSBC_DEADBAT = 3'h4
    } psbc_mode_t;
endpackage

/* src/psbc_sync.sv */
// Purpose: Two-stage synchroniser with rising-edge count for the reference clock pin.
// Assumes: Input is asynchronous; first stage feeds only the second.
// Notes: Counts rising edges up to a saturating limit.
`timescale 1ns/1ps
`default_nettype none
module psbc_sync #(
    parameter int CNT_W = 3,
    parameter logic [CNT_W-1:0] LIMIT = 3'h4
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic din,
    output logic seen
);
    logic meta;
    logic stable;
    logic last;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    always_comb
    begin
        next_count = count;
        if (stable && !last && count != LIMIT)
        begin
            next_count = count + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            meta <= 1'b0;
            stable <= 1'b0;
            last <= 1'b0;
            count <= '0;
            seen <= 1'b0;
        end
        else
        begin
            meta <= din;
            stable <= meta;
            last <= stable;
            count <= next_count;
            seen <= (next_count == LIMIT);
        end
    end
endmodule
`default_nettype wire

/* src/psbc_top.sv */
// Purpose: Sideband pin control of a standalone USB transceiver.
// Assumes: Inputs synchronous to core_clk except ref_clock_in; nrst is active low.
// Notes: Register bits arrive as plain ports from the link-side register file.
`timescale 1ns/1ps
`default_nettype none
module psbc_top (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic freqSelStrap,
    input wire logic charge_detect_polarity_strap,
    input wire logic chipSelectN,
    input wire logic chipSelect,
    input wire logic dead_battery_detect_enable_n,
    input wire logic frameEnable,
    input wire logic hsSofSeen,
    input wire logic faultIn,
    input wire logic use_ext_power_indicator,
    input wire logic indicator_invert,
    input wire logic indicator_qualify_bypass,
    input wire logic busValidCmp,
    input wire logic chargerDetected,
    input wire logic driveBusPower,
    input wire logic switch_drive_mode,
    input wire logic ref_clock_in,
    output logic refIs26M,
    output logic frameOut,
    output logic powerDown,
    output logic ulpiOe,
    output psbc_pkg::psbc_mode_t mode,
    output logic deadBatDetectRun,
    output logic extIndicator,
    output logic charge_detect_out,
    output logic charge_detect_out_oe,
    output logic bus_power_switch_ctrl,
    output logic bus_power_switch_ctrl_oe,
    output logic ulpiClkOe
);
    import psbc_pkg::*;

    logic rstMeta;
    logic rstN;
    logic strapsTaken;
    logic polStrap;
    logic next_strapsTaken;
    logic next_refIs26M;
    logic next_polStrap;
    logic next_frameOut;
    logic selected;
    psbc_mode_t next_mode;
    logic next_deadBat;
    logic next_extIndicator;
    logic faultLevel;
    logic chgLevel;
    logic swLevel;
    logic refSeen;

    // Reset release is synchronised; assertion stays asynchronous.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // Straps are captured once, on the first clock after reset release.
    always_comb
    begin
        next_strapsTaken = 1'b1;
        next_refIs26M = refIs26M;
        next_polStrap = polStrap;
        if (!strapsTaken)
        begin
            next_refIs26M = (freqSelStrap == FREQ_SEL_26M);
            next_polStrap = charge_detect_polarity_strap;
        end
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            strapsTaken <= 1'b0;
            refIs26M <= 1'b0;
            polStrap <= 1'b0;
        end
        else
        begin
            strapsTaken <= next_strapsTaken;
            refIs26M <= next_refIs26M;
            polStrap <= next_polStrap;
        end
    end

    // Mode: select pins decide power down; dead-battery detection only outside active mode.
    always_comb
    begin
        selected = !chipSelectN && chipSelect;
        next_mode = mode;
        case (mode)
            PSBC_OFF:
            begin
                if (selected)
                begin
                    next_mode = PSBC_ACTIVE;
                end
                else if (!dead_battery_detect_enable_n)
                begin
                    next_mode = PSBC_DEADBAT;
                end
            end
            PSBC_ACTIVE:
            begin
                if (!selected)
                begin
                    next_mode = PSBC_OFF;
                end
            end
            PSBC_DEADBAT:
            begin
                if (selected)
                begin
                    next_mode = PSBC_ACTIVE;
                end
                else if (dead_battery_detect_enable_n)
                begin
                    next_mode = PSBC_OFF;
                end
            end
            default:
            begin
                next_mode = PSBC_OFF;
            end
        endcase
        next_deadBat = (next_mode == PSBC_DEADBAT);
    end

    // Frame pulse, indicator and pin drive logic.
    always_comb
    begin
        next_frameOut = 1'b0;
        if (frameEnable && next_mode == PSBC_ACTIVE)
        begin
            next_frameOut = frameOut ^ hsSofSeen;
        end
        faultLevel = faultIn ^ indicator_invert;
        next_extIndicator = 1'b0;
        if (use_ext_power_indicator)
        begin
            next_extIndicator = indicator_qualify_bypass ? faultLevel : (faultLevel && busValidCmp);
        end
        chgLevel = (polStrap == POL_ACTIVE_LOW) ? !chargerDetected : chargerDetected;
        swLevel = (switch_drive_mode == DRIVE_ACTIVE_HIGH) ? driveBusPower : !driveBusPower;
    end

    always_ff @(posedge core_clk or negedge rstN)
    begin
        if (!rstN)
        begin
            mode <= PSBC_OFF;
            deadBatDetectRun <= 1'b0;
            frameOut <= 1'b0;
            powerDown <= 1'b1;
            ulpiOe <= 1'b0;
            extIndicator <= 1'b0;
            charge_detect_out <= 1'b0;
            charge_detect_out_oe <= 1'b0;
            bus_power_switch_ctrl <= 1'b0;
            bus_power_switch_ctrl_oe <= 1'b0;
            ulpiClkOe <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            deadBatDetectRun <= next_deadBat;
            frameOut <= next_frameOut;
            powerDown <= (next_mode != PSBC_ACTIVE);
            ulpiOe <= (next_mode == PSBC_ACTIVE);
            extIndicator <= next_extIndicator;
            // Open-drain or open-source: drive only the active level.
            charge_detect_out <= chgLevel;
            charge_detect_out_oe <= chargerDetected;
            bus_power_switch_ctrl <= swLevel;
            bus_power_switch_ctrl_oe <= driveBusPower;
            ulpiClkOe <= refSeen && (next_mode == PSBC_ACTIVE);
        end
    end

    psbc_sync #(
        .CNT_W(REF_CNT_W),
        .LIMIT(REF_CNT_W'(REF_DETECT_EDGES))
    ) refDetect (
        .clk(core_clk),
        .rstN(rstN),
        .din(ref_clock_in),
        .seen(refSeen)
    );
endmodule
`default_nettype wire
